/* File: core/flash_guard_pkg.sv */
// Constants and types for the flash guard and programmer port block
package flash_guard_pkg;
  // APB register byte offsets
  localparam logic [7:0] ctrl_one_off = 8'h00;
  localparam logic [7:0] ctrl_two_off = 8'h04;
  localparam logic [7:0] erase_sel_off = 8'h08;
  localparam logic [7:0] cpu_event_off = 8'h0c;
  // Control one fields
  localparam int prog_bit = 0;
  localparam int erase_bit = 1;
  localparam int burn_check_bit = 2;
  localparam int clear_check_bit = 3;
  localparam int write_guard_off_bit = 6;
  // Control two fields
  localparam int flash_error_bit = 7;
  // Status word fields in control two readback
  localparam int prog_mode_bit = 8;
  localparam int erase_mode_bit = 9;
  localparam int irq_block_bit = 10;
  // Reset values
  localparam logic [7:0] ctrl_one_rst = 8'h00;
  localparam logic [7:0] ctrl_two_rst = 8'h00;
  localparam logic [7:0] erase_sel_rst = 8'h00;
  // Programmer command codes
  localparam logic [7:0] cmd_read = 8'h00;
  localparam logic [7:0] cmd_program = 8'h40;
  localparam logic [7:0] cmd_erase = 8'h20;
  localparam logic [7:0] cmd_status = 8'h71;
  // Programmer address range and page
  localparam logic [15:0] flash_top = 16'hefff;
  localparam int page_bytes = 128;
  localparam int page_low_bits = 7;
  // Status return code bits
  localparam int st_abnormal = 7;
  localparam int st_cmd_err = 6;
  localparam int st_addr_err = 0;
  // Programmer state
  typedef enum logic [2:0] {
    pm_read, pm_wait, pm_erase2, pm_status2, pm_load, pm_status
  } pm_state_t;
endpackage

/* File: core/flash_guard.sv */
// Flash program/erase protection and programmer command port
`timescale 1ns/1ps
module flash_guard
  import flash_guard_pkg::*;
(
  // Clock and resets
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic por,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU and power events
  input wire logic low_power_entry,
  input wire logic boot_running,
  input wire logic exception_start,
  input wire logic sleep_exec,
  input wire logic flash_read_busy_area,
  output logic irq_block,
  output logic prog_mode,
  output logic erase_mode,
  output logic burn_check,
  output logic clear_check,
  output logic [7:0] erase_enable,
  // Programmer port
  input wire logic prog_we,
  input wire logic prog_oe,
  input wire logic [15:0] prog_addr,
  input wire logic [7:0] prog_din,
  input wire logic prog_op_done,
  input wire logic prog_op_fail,
  output logic [7:0] prog_dout,
  output logic prog_dout_oe_n,
  output logic prog_start,
  output logic erase_start,
  output logic [15:0] read_addr,
  input wire logic [7:0] mem_rdata,
  output logic [7:0] page_data [page_bytes],
  output logic [15:0] write_addr
);
  logic [7:0] c1_q, c1_d, c2_q, ebr_q;
  logic err_q, err_d;
  logic pm_q, em_q;
  logic [31:0] rd_d;
  logic wr_en, rd_en, c1_sel, c2_sel, ebr_sel, map_ok;
  logic busy, fault;
  pm_state_t st_q, st_d;
  logic [7:0] code_q, code_d, cnt_q, cnt_d;
  logic busy_op_q, busy_op_d;
  logic [7:0] dout_d;
  logic guard_ok, prog_go, erase_go, code_keep;

  // APB decode, zero wait states
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign c1_sel = paddr == ctrl_one_off;
  assign c2_sel = paddr == ctrl_two_off;
  assign ebr_sel = paddr == erase_sel_off;
  assign map_ok = c1_sel || c2_sel || ebr_sel;

  // Error detection while programming or erasing
  assign busy = pm_q || em_q;
  assign fault = busy && (flash_read_busy_area
    || exception_start
    || sleep_exec);
  assign err_d = err_q || fault;

  // Mode requests gated by the write guard and the error lock.
  // Interrupt blocking follows the real modes, not the raw bits,
  // so a guarded write never masks interrupts by itself.
  assign guard_ok = c1_d[write_guard_off_bit] && !err_d;
  assign prog_go = c1_d[prog_bit] && guard_ok;
  assign erase_go = c1_d[erase_bit] && guard_ok
    && (ebr_q != 8'h00);

  // Control one next value; verify bits allowed under error
  assign c1_d = (wr_en && c1_sel) ? pwdata[7:0] : c1_q;

  assign rd_d = c1_sel ? {24'h0, c1_q} :
    c2_sel ? {21'h0, irq_block, em_q, pm_q, c2_q} :
    ebr_sel ? {24'h0, ebr_q} : 32'h0;

  // Control registers; low power aborts and clears, error keeps them
  always_ff @(posedge clk_sys)
  begin
    if (srst || low_power_entry)
    begin
      c1_q <= ctrl_one_rst;
      ebr_q <= erase_sel_rst;
    end
    else
    begin
      c1_q <= c1_d;
      if (wr_en && ebr_sel)
        ebr_q <= pwdata[7:0];
    end
  end

  // Error flag, power-on reset only
  always_ff @(posedge clk_sys)
  begin
    if (por)
      err_q <= 1'b0;
    else
      err_q <= err_d;
  end

  // Mode outputs gated by write guard and error protection; burn_check and clear_check follow control one ungated
  always_ff @(posedge clk_sys)
  begin
    if (srst || low_power_entry)
    begin
      pm_q <= 1'b0;
      em_q <= 1'b0;
      burn_check <= 1'b0;
      clear_check <= 1'b0;
      erase_enable <= 8'h00;
      irq_block <= 1'b0;
      prog_mode <= 1'b0;
      erase_mode <= 1'b0;
    end
    else
    begin
      pm_q <= prog_go;
      em_q <= erase_go;
      prog_mode <= prog_go;
      erase_mode <= erase_go;
      burn_check <= c1_d[burn_check_bit];
      clear_check <= c1_d[clear_check_bit];
      erase_enable <= ebr_q & {8{guard_ok}};
      irq_block <= prog_go || erase_go || boot_running;
    end
  end

  // APB read data and response
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      if (rd_en)
        prdata <= rd_d;
      pready <= psel && !penable;
      pslverr <= psel && !penable && !map_ok;
    end
  end
  assign c2_q = {err_q, 7'h0};

  // Programmer command decode
  always_comb
  begin
    st_d = st_q;
    code_d = code_q;
    cnt_d = cnt_q;
    busy_op_d = busy_op_q;
    if (busy_op_q)
    begin
      if (prog_op_done)
      begin
        busy_op_d = 1'b0;
        code_d[st_abnormal] = prog_op_fail;
        st_d = pm_wait;
      end
    end
    else if (prog_we)
    begin
      unique case (st_q)
        pm_read, pm_wait, pm_status:
        begin
          if (!code_keep)
            code_d = 8'h00;
          if (prog_din == cmd_read)
            st_d = pm_read;
          else if (prog_din == cmd_program)
          begin
            st_d = pm_load;
            cnt_d = 8'h00;
          end
          else if (prog_din == cmd_erase)
            st_d = pm_erase2;
          else if (prog_din == cmd_status)
            st_d = pm_status2;
          else
          begin
            code_d[st_cmd_err] = 1'b1;
            st_d = pm_wait;
          end
        end
        pm_erase2:
        begin
          if (prog_din == cmd_erase)
            busy_op_d = 1'b1;
          else
          begin
            code_d[st_cmd_err] = 1'b1;
            code_d[st_abnormal] = 1'b1;
          end
          st_d = pm_wait;
        end
        pm_status2:
        begin
          if (prog_din == cmd_status)
            st_d = pm_status;
          else
          begin
            code_d[st_cmd_err] = 1'b1;
            code_d[st_abnormal] = 1'b1;
            st_d = pm_wait;
          end
        end
        pm_load:
        begin
          if (cnt_q == 8'h00 && (prog_addr[page_low_bits-1:0] != 7'h0
            || prog_addr > flash_top))
          begin
            code_d[st_addr_err] = 1'b1;
            code_d[st_abnormal] = 1'b1;
          end
          cnt_d = cnt_q + 8'h01;
          if (cnt_q == 8'(page_bytes - 1))
          begin
            busy_op_d = 1'b1;
            st_d = pm_wait;
          end
        end
      endcase
    end
  end

  // Status command keeps the return code; any other command clears it
  assign code_keep = prog_din == cmd_status;

  // Data out: status polling, status code or memory byte
  assign dout_d = busy_op_q ? {1'b0, 7'h0} :
    (st_q == pm_status) ? code_q :
    (st_q == pm_read) ? mem_rdata : {1'b1, code_q[st_abnormal], 6'h0};

  // Programmer state registers; power-up enters read mode
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      st_q <= pm_read;
      code_q <= 8'h00;
      cnt_q <= 8'h00;
      busy_op_q <= 1'b0;
      prog_dout <= 8'h00;
      prog_dout_oe_n <= 1'b1;
      prog_start <= 1'b0;
      erase_start <= 1'b0;
      read_addr <= 16'h0;
      write_addr <= 16'h0;
    end
    else
    begin
      st_q <= st_d;
      code_q <= code_d;
      cnt_q <= cnt_d;
      busy_op_q <= busy_op_d;
      prog_dout <= dout_d;
      prog_dout_oe_n <= !prog_oe;
      prog_start <= busy_op_d && !busy_op_q && st_q == pm_load;
      erase_start <= busy_op_d && !busy_op_q && st_q == pm_erase2;
      if (prog_addr <= flash_top)
        read_addr <= prog_addr;
      if (prog_we && st_q == pm_load && cnt_q == 8'h00)
        write_addr <= prog_addr;
    end
  end

  // Page latch, one byte per write cycle
  genvar gi;
  generate
    for (gi = 0; gi < page_bytes; gi++)
    begin : g_page
      always_ff @(posedge clk_sys)
      begin
        if (srst)
          page_data[gi] <= 8'hff;
        else if (prog_we && st_q == pm_load && !busy_op_q
          && cnt_q == 8'(gi))
          page_data[gi] <= prog_din;
      end
    end
  endgenerate
endmodule // flash_guard

/* File: tb/flash_guard_properties.sv */
// Port checks for the flash guard block
`timescale 1ns/1ps
module flash_guard_properties
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Watched ports
  input wire logic psel,
  input wire logic pslverr,
  input wire logic low_power_entry,
  input wire logic boot_running,
  input wire logic exception_start,
  input wire logic sleep_exec,
  input wire logic flash_read_busy_area,
  input wire logic irq_block,
  input wire logic prog_mode,
  input wire logic erase_mode,
  input wire logic [7:0] erase_enable,
  input wire logic prog_start,
  input wire logic erase_start
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Either flash mode active
  wire busy = prog_mode | erase_mode;
  // Error event drops an active mode
  property err_stop(ev);
    ev && busy |=> ##[0:1] !busy;
  endproperty
  a_irq_held_busy: assert property ((busy || boot_running) |-> ##[0:1] irq_block)
    else $error("interrupts not blocked");
  a_low_power_clears: assert property (low_power_entry |=> !busy && erase_enable == 8'h00)
    else $error("low power entry left state");
  a_erase_needs_sel: assert property (erase_mode |-> erase_enable != 8'h00)
    else $error("erase mode with no block");
  a_read_busy_err: assert property (err_stop(flash_read_busy_area))
    else $error("busy read did not abort");
  a_exception_err: assert property (err_stop(exception_start))
    else $error("exception did not abort");
  a_sleep_err: assert property (err_stop(sleep_exec))
    else $error("sleep did not abort");
  a_prog_pulse: assert property (prog_start |=> !prog_start)
    else $error("program start too long");
  a_erase_pulse: assert property (erase_start |=> !erase_start)
    else $error("erase start too long");
  // Main scenarios
  c_prog: cover property (prog_start);
  c_erase: cover property (erase_start);
  c_slverr: cover property (psel && pslverr);
endmodule // flash_guard_properties

bind flash_guard flash_guard_properties chk (.clk_sys, .srst, .psel, .pslverr,
  .low_power_entry, .boot_running, .exception_start, .sleep_exec,
  .flash_read_busy_area, .irq_block, .prog_mode, .erase_mode, .erase_enable,
  .prog_start, .erase_start);

/* File: tb/prom_programmer.sv */
// Programmer model issuing command and read cycles
`timescale 1ns/1ps
module prom_programmer
(
  // Clock
  input wire logic clk_sys,
  // Programmer port
  output logic prog_we,
  output logic prog_oe,
  output logic [15:0] prog_addr,
  output logic [7:0] prog_din,
  input wire logic [7:0] prog_dout,
  input wire logic prog_dout_oe_n
);
  initial
  begin
    prog_we = 1'b0;
    prog_oe = 1'b0;
    prog_addr = 16'h0000;
    prog_din = 8'h00;
  end
  // One write cycle; data line inverted once released
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    prog_we <= 1'b1;
    prog_addr <= a;
    prog_din <= d;
    @(posedge clk_sys);
    prog_we <= 1'b0;
    prog_din <= ~d;
  endtask
  // One read cycle
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic z);
    @(posedge clk_sys);
    prog_oe <= 1'b1;
    prog_addr <= a;
    repeat (3) @(posedge clk_sys);
    d = prog_dout;
    z = prog_dout_oe_n;
    prog_oe <= 1'b0;
    prog_addr <= ~a;
  endtask
endmodule // prom_programmer

/* File: tb/flash_guard_bench.sv */
// Self-checking bench for the flash guard block
`timescale 1ns/1ps
module flash_guard_bench;
  import flash_guard_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic por = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic low_power_entry = 1'b0;
  logic boot_running = 1'b0;
  logic [2:0] evs = 3'h0;
  logic prog_op_done = 1'b0;
  logic prog_we, prog_oe, pready, pslverr, slv, irq_block, prog_mode, z;
  logic erase_mode, burn_check, clear_check, prog_dout_oe_n, prog_start;
  logic erase_start;
  logic [15:0] prog_addr, read_addr, write_addr;
  logic [7:0] prog_din, prog_dout, b, erase_enable;
  logic [7:0] page_data [page_bytes];
  logic [31:0] prdata, r;
  int errors = 0;
  int comparisons = 0;
  int n_er = 0;
  int i;
  // Mode outputs packed for compares
  wire [31:0] st = {19'h0, erase_enable, irq_block, prog_mode, erase_mode,
    burn_check, clear_check};
  // Flash array stand-in
  wire [7:0] mem_rdata = read_addr[7:0] ^ 8'ha5;
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (erase_start === 1'b1) n_er <= n_er + 1;
  flash_guard DUT (.clk_sys, .srst, .por, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .low_power_entry, .boot_running,
    .exception_start(evs[1]), .sleep_exec(evs[2]),
    .flash_read_busy_area(evs[0]), .irq_block, .prog_mode, .erase_mode,
    .burn_check, .clear_check, .erase_enable, .prog_we, .prog_oe, .prog_addr,
    .prog_din, .prog_op_done, .prog_op_fail(1'b0), .prog_dout, .prog_dout_oe_n,
    .prog_start, .erase_start, .read_addr, .mem_rdata, .page_data, .write_addr);
  prom_programmer pp (.clk_sys, .prog_we, .prog_oe, .prog_addr, .prog_din,
    .prog_dout, .prog_dout_oe_n);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One APB transfer, result left in r and slv
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  // Power-on reset pulse
  task automatic pulse_por;
    @(posedge clk_sys);
    por <= 1'b1;
    @(posedge clk_sys);
    por <= 1'b0;
    settle();
  endtask
  task automatic results;
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    results();
  end
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    por <= 1'b0;
    apb(0, ctrl_one_off, 0);
    chk(r, {24'h0, ctrl_one_rst});
    apb(0, 8'h10, 0);
    chk({31'h0, slv}, 32'h1);
    apb(1, ctrl_one_off, 32'h01);
    settle();
    chk(st, 32'h0);
    for (i = 0; i < 3; i++)
    begin
      apb(1, ctrl_one_off, 32'h0);
      pulse_por();
      apb(1, ctrl_one_off, 32'h41);
      settle();
      chk(st, 32'h18);
      evs <= 3'(1 << i);
      @(posedge clk_sys);
      evs <= 3'h0;
      settle();
      chk(st, 32'h0);
      apb(0, ctrl_two_off, 0);
      chk(r & 32'h80, 32'h80);
    end
    apb(0, ctrl_one_off, 0);
    chk(r, 32'h41);
    apb(1, ctrl_one_off, 32'h45);
    settle();
    chk(st, 32'h02);
    srst <= 1'b1;
    @(posedge clk_sys);
    srst <= 1'b0;
    apb(0, ctrl_two_off, 0);
    chk(r & 32'h80, 32'h80);
    apb(0, ctrl_one_off, 0);
    chk(r, 32'h0);
    pulse_por();
    apb(0, ctrl_two_off, 0);
    chk(r & 32'h80, 32'h0);
    $display("cpu protection test done");
    apb(1, ctrl_one_off, 32'h42);
    settle();
    chk(st, 32'h0);
    apb(1, erase_sel_off, 32'h01);
    settle();
    chk(st, 32'h34);
    low_power_entry <= 1'b1;
    @(posedge clk_sys);
    low_power_entry <= 1'b0;
    settle();
    chk(st, 32'h0);
    boot_running <= 1'b1;
    settle();
    chk(st, 32'h10);
    boot_running <= 1'b0;
    $display("erase and boot test done");
    pp.rd(16'h0012, b, z);
    chk({23'h0, z, b}, {24'h0, 8'h12 ^ 8'ha5});
    pp.wr(16'h0000, cmd_program);
    for (i = 0; i < page_bytes; i++) pp.wr(16'h0080 + 16'(i), 8'(i));
    for (i = 0; i < 20 && prog_start !== 1'b1; i++) @(posedge clk_sys);
    chk({write_addr, 8'h0, page_data[5]}, 32'h00800005);
    prog_op_done <= 1'b1;
    @(posedge clk_sys);
    prog_op_done <= 1'b0;
    pp.rd(16'h0000, b, z);
    chk({24'h0, b & 8'hc0}, 32'h80);
    pp.wr(16'h0000, cmd_read);
    pp.rd(16'h0040, b, z);
    chk({24'h0, b}, {24'h0, 8'h40 ^ 8'ha5});
    pp.rd(flash_top, b, z);
    chk({24'h0, b}, {24'h0, 8'hff ^ 8'ha5});
    $display("programmer program test done");
    pp.wr(16'h0000, cmd_erase);
    pp.wr(16'h0000, cmd_status);
    pp.wr(16'h0000, cmd_status);
    pp.wr(16'h0000, cmd_status);
    pp.rd(16'h0000, b, z);
    chk({24'h0, b & 8'hc0}, 32'hc0);
    pp.rd(16'h0001, b, z);
    chk({24'h0, b & 8'hc0}, 32'hc0);
    chk(n_er, 0);
    pp.wr(16'h0000, cmd_read);
    pp.wr(16'h0000, cmd_erase);
    pp.wr(16'h0000, cmd_erase);
    settle();
    chk(n_er, 1);
    $display("programmer erase test done");
    results();
  end
endmodule // flash_guard_bench
